//--- hw/fpgp_defs.vh
// constants for the five-pin general-purpose port: offsets, field layout,
// reset values and field encodings; included by every design file of the port
`ifndef FPGP_DEFS_VH
`define FPGP_DEFS_VH

`define FPGP_PINS 5
`define FPGP_ADDR_W 12

// register byte offsets
`define FPGP_OFF_MODE 12'h000
`define FPGP_OFF_PULL 12'h004
`define FPGP_OFF_IBUF 12'h008
`define FPGP_OFF_INPUT 12'h010
`define FPGP_OFF_OUTPUT 12'h014
`define FPGP_OFF_LOCK 12'h018
`define FPGP_OFF_ALT 12'h030
`define FPGP_OFF_BCTL_BASE 12'h100
`define FPGP_BCTL_STRIDE 12'h004

// field layout
`define FPGP_FIELD2_W 10
`define FPGP_ALT_W 20
`define FPGP_ALT_FIELD_W 4
`define FPGP_INV_LSB 16
`define FPGP_INV_MSB 20
`define FPGP_BCTL_BIT 0

// reset values
`define FPGP_RST_FIELD2 10'h000
`define FPGP_RST_PINS 5'h00
`define FPGP_RST_ALT 20'h00000
`define FPGP_RST_WORD 32'h00000000
`define FPGP_RST_SCHMITT 5'h1F

// mode field
`define FPGP_MODE_INPUT 2'h0
`define FPGP_MODE_PUSH 2'h1
`define FPGP_MODE_DRAIN 2'h2
// pull field
`define FPGP_PULL_FLOAT 2'h0
`define FPGP_PULL_DOWN 2'h1
`define FPGP_PULL_UP 2'h2
// input-buffer field: upper bit set disables the input
`define FPGP_IBUF_OFF_BIT 1
// alternate field: zero keeps the pin under port control
`define FPGP_ALT_GPIO 4'h0

`endif

//--- hw/fpgp_pin_cell.v
// per-pin pad control: turns one pin's configuration fields into drive,
// enable, pull and input-buffer controls; purely combinational
// assumes the caller registers the results before they reach the pad
`timescale 1ns/100ps
`default_nettype none
`include "fpgp_defs.vh"

module fpgp_pin_cell (
    input wire [1:0] i_mode,
    input wire [1:0] i_pull,
    input wire [1:0] i_ibuf,
    input wire [3:0] i_alt_sel,
    input wire i_out_bit,
    input wire i_alt_out,
    input wire i_alt_oe,
    output reg o_pad_out,
    output reg o_pad_oe,
    output reg o_pull_up,
    output reg o_pull_down,
    output reg o_schmitt,
    output reg o_input_mode
);

    reg alt_active;
    reg analog;
    reg pulls_ok;

    always @* begin
        alt_active = (i_alt_sel != `FPGP_ALT_GPIO);
        analog = (i_mode == `FPGP_MODE_INPUT) && (i_pull == `FPGP_PULL_FLOAT)
            && i_ibuf[`FPGP_IBUF_OFF_BIT];
        o_pad_out = 1'b0;
        o_pad_oe = 1'b0;
        pulls_ok = 1'b0;
        o_input_mode = 1'b0;
        o_schmitt = ~i_ibuf[`FPGP_IBUF_OFF_BIT];
        if (alt_active) begin
            // peripheral owns value and direction; pulls stay software's
            pulls_ok = 1'b1;
            case (i_mode)
                `FPGP_MODE_DRAIN: begin
                    o_pad_oe = i_alt_oe & i_alt_out;
                end
                `FPGP_MODE_PUSH,
                `FPGP_MODE_INPUT: begin
                    o_pad_out = i_alt_out;
                    o_pad_oe = i_alt_oe;
                end
                default: begin
                    o_pad_oe = 1'b0;
                end
            endcase
        end else begin
            case (i_mode)
                `FPGP_MODE_INPUT: begin
                    o_input_mode = 1'b1;
                    pulls_ok = ~analog;
                end
                `FPGP_MODE_PUSH: begin
                    o_pad_out = i_out_bit;
                    o_pad_oe = 1'b1;
                end
                `FPGP_MODE_DRAIN: begin
                    o_pad_oe = i_out_bit;
                end
                default: begin
                    o_pad_oe = 1'b0;
                end
            endcase
        end
        if (analog && !alt_active) begin
            o_schmitt = 1'b0;
        end
        // reserved pull code 11 enables neither resistor
        o_pull_up = pulls_ok && (i_pull == `FPGP_PULL_UP);
        o_pull_down = pulls_ok && (i_pull == `FPGP_PULL_DOWN);
    end

endmodule
`default_nettype wire

//--- hw/fpgp_port.v
// five-pin general-purpose port: register file, input sampling and
// registered pad controls for five pins
// assumes a single 40 MHz clock, a simple strobe register port and
// pad pins that arrive asynchronously
//
// Contract
// - two-bit mode per pin: 00 input, 01 push-pull, 10 open-drain, 11 reserved.
// - mode fields packed two bits per pin, pin n at bits 2n+1:2n.
// - two-bit pull per pin: 00 floating, 01 pull-down, 10 pull-up.
// - input-buffer field 00 enables Schmitt input; upper bit set forces input zero.
// - input data captured from pin every clock in every digital mode.
// - input mode: driver off, pulls follow the pull field.
// - push-pull: pin driven to the output data bit.
// - open-drain: output bit 1 pulls low, 0 leaves pin floating.
// - push-pull, open-drain and analog modes disable both pulls.
// - digital modes use a Schmitt-trigger input path.
// - alternate mode takes output value from the peripheral.
// - alternate mode: peripheral sets direction, pulls stay software controlled.
// - analog (00,00,1x): driver and Schmitt off, input bit reads zero.
// - each pin can raise an external interrupt while in input mode.
// - invert bit at 16+n makes input bit report the inverted pin level.
// - input bits at bit n are read-only.
// - output lock bit set blocks writes to that output bit.
// - per-pin bit-control register: bit 0 sets or clears output bit.
`timescale 1ns/100ps
`default_nettype none
`include "fpgp_defs.vh"

module fpgp_port (
    input wire i_clk,
    input wire i_reset,
    input wire [11:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    input wire [4:0] i_pin_in,
    output reg [4:0] o_pin_out,
    output reg [4:0] o_pin_oe,
    output reg [4:0] o_pull_up_en,
    output reg [4:0] o_pull_down_en,
    output reg [4:0] o_schmitt_en,
    input wire [4:0] i_alt_out,
    input wire [4:0] i_alt_oe,
    output reg [4:0] o_alt_in,
    output reg [4:0] o_ext_int_src
);

    // software state
    reg [9:0] pin_mode_config;
    reg [9:0] pin_pull_config;
    reg [9:0] pin_input_buffer_config;
    reg [4:0] pin_input_invert;
    reg [4:0] pin_input_value;
    reg [4:0] pin_output_value;
    reg [4:0] pin_output_write_lock;
    reg [19:0] pin_alternate_select;

    // pin synchroniser; stage one feeds stage two only
    reg [4:0] pin_sync_a;
    reg [4:0] pin_sync_b;

    reg [4:0] next_output_value;
    reg [31:0] next_rdata;
    reg [4:0] bctl_hit;

    wire [4:0] cell_out;
    wire [4:0] cell_oe;
    wire [4:0] cell_pu;
    wire [4:0] cell_pd;
    wire [4:0] cell_st;
    wire [4:0] cell_in_mode;
    wire [4:0] ibuf_off;

    // one-hot for the pin addressed by a bit-control word, zero if none
    function [4:0] bctl_decode;
        input [11:0] addr;
        reg [11:0] rel;
        begin
            bctl_decode = 5'h00;
            rel = addr - `FPGP_OFF_BCTL_BASE;
            if (addr >= `FPGP_OFF_BCTL_BASE && rel[1:0] == 2'h0 && rel[11:2] < 10'd5) begin
                bctl_decode = 5'h01 << rel[4:2];
            end
        end
    endfunction

    // pick the odd bits of a packed two-bit field vector
    function [4:0] upper_bits;
        input [9:0] field;
        integer k;
        begin
            upper_bits = 5'h00;
            for (k = 0; k < `FPGP_PINS; k = k + 1) begin
                upper_bits[k] = field[2 * k + 1];
            end
        end
    endfunction

    assign ibuf_off = upper_bits(pin_input_buffer_config);

    genvar n;
    generate
        for (n = 0; n < `FPGP_PINS; n = n + 1) begin : g_pin
            fpgp_pin_cell u_cell (
                .i_mode(pin_mode_config[2 * n + 1:2 * n]),
                .i_pull(pin_pull_config[2 * n + 1:2 * n]),
                .i_ibuf(pin_input_buffer_config[2 * n + 1:2 * n]),
                .i_alt_sel(pin_alternate_select[4 * n + 3:4 * n]),
                .i_out_bit(pin_output_value[n]),
                .i_alt_out(i_alt_out[n]),
                .i_alt_oe(i_alt_oe[n]),
                .o_pad_out(cell_out[n]),
                .o_pad_oe(cell_oe[n]),
                .o_pull_up(cell_pu[n]),
                .o_pull_down(cell_pd[n]),
                .o_schmitt(cell_st[n]),
                .o_input_mode(cell_in_mode[n])
            );
        end
    endgenerate

    always @* begin
        bctl_hit = bctl_decode(i_addr);
    end

    // output data: register word and bit-control words both honour the lock
    always @* begin
        next_output_value = pin_output_value;
        if (i_wr && i_addr == `FPGP_OFF_OUTPUT) begin
            next_output_value = (pin_output_value & pin_output_write_lock)
                | (i_wdata[4:0] & ~pin_output_write_lock);
        end else if (i_wr && bctl_hit != 5'h00) begin
            if (i_wdata[`FPGP_BCTL_BIT]) begin
                next_output_value = pin_output_value | (bctl_hit & ~pin_output_write_lock);
            end else begin
                next_output_value = pin_output_value & ~(bctl_hit & ~pin_output_write_lock);
            end
        end
    end

    // configuration writes; only documented bits are stored
    always @(posedge i_clk) begin
        if (i_reset) begin
            pin_mode_config <= `FPGP_RST_FIELD2;
            pin_pull_config <= `FPGP_RST_FIELD2;
            pin_input_buffer_config <= `FPGP_RST_FIELD2;
            pin_input_invert <= `FPGP_RST_PINS;
            pin_output_value <= `FPGP_RST_PINS;
            pin_output_write_lock <= `FPGP_RST_PINS;
            pin_alternate_select <= `FPGP_RST_ALT;
        end else begin
            pin_output_value <= next_output_value;
            if (i_wr) begin
                case (i_addr)
                    `FPGP_OFF_MODE: begin
                        pin_mode_config <= i_wdata[9:0];
                    end
                    `FPGP_OFF_PULL: begin
                        pin_pull_config <= i_wdata[9:0];
                    end
                    `FPGP_OFF_IBUF: begin
                        pin_input_buffer_config <= i_wdata[9:0];
                    end
                    `FPGP_OFF_INPUT: begin
                        // input bits themselves ignore the write
                        pin_input_invert <= i_wdata[`FPGP_INV_MSB:`FPGP_INV_LSB];
                    end
                    `FPGP_OFF_LOCK: begin
                        pin_output_write_lock <= i_wdata[4:0];
                    end
                    `FPGP_OFF_ALT: begin
                        pin_alternate_select <= i_wdata[19:0];
                    end
                    default: begin
                        pin_output_write_lock <= pin_output_write_lock;
                    end
                endcase
            end
        end
    end

    // pin sampling: two flops, then the input value register every cycle
    always @(posedge i_clk) begin
        if (i_reset) begin
            pin_sync_a <= `FPGP_RST_PINS;
            pin_sync_b <= `FPGP_RST_PINS;
            pin_input_value <= `FPGP_RST_PINS;
        end else begin
            pin_sync_a <= i_pin_in;
            pin_sync_b <= pin_sync_a;
            // a disabled buffer reads zero whatever the inversion says
            pin_input_value <= (pin_sync_b ^ pin_input_invert) & ~ibuf_off;
        end
    end

    // read mux; the answer stands for the one cycle after the strobe
    always @* begin
        next_rdata = `FPGP_RST_WORD;
        if (i_rd) begin
            case (i_addr)
                `FPGP_OFF_MODE: begin
                    next_rdata[9:0] = pin_mode_config;
                end
                `FPGP_OFF_PULL: begin
                    next_rdata[9:0] = pin_pull_config;
                end
                `FPGP_OFF_IBUF: begin
                    next_rdata[9:0] = pin_input_buffer_config;
                end
                `FPGP_OFF_INPUT: begin
                    next_rdata[4:0] = pin_input_value;
                    next_rdata[`FPGP_INV_MSB:`FPGP_INV_LSB] = pin_input_invert;
                end
                `FPGP_OFF_OUTPUT: begin
                    next_rdata[4:0] = pin_output_value;
                end
                `FPGP_OFF_LOCK: begin
                    next_rdata[4:0] = pin_output_write_lock;
                end
                `FPGP_OFF_ALT: begin
                    next_rdata[19:0] = pin_alternate_select;
                end
                default: begin
                    // bit-control words read back their pin's output bit
                    next_rdata[0] = |(bctl_hit & pin_output_value);
                end
            endcase
        end
    end

    // pad controls registered so every output comes from a flop;
    // this costs one cycle from register write to pin
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= `FPGP_RST_WORD;
            o_pin_out <= `FPGP_RST_PINS;
            o_pin_oe <= `FPGP_RST_PINS;
            o_pull_up_en <= `FPGP_RST_PINS;
            o_pull_down_en <= `FPGP_RST_PINS;
            o_schmitt_en <= `FPGP_RST_SCHMITT;
            o_alt_in <= `FPGP_RST_PINS;
            o_ext_int_src <= `FPGP_RST_PINS;
        end else begin
            o_rdata <= next_rdata;
            o_pin_out <= cell_out;
            o_pin_oe <= cell_oe;
            o_pull_up_en <= cell_pu;
            o_pull_down_en <= cell_pd;
            o_schmitt_en <= cell_st;
            // peripherals see the true pin level, gated by the input buffer
            o_alt_in <= pin_sync_b & ~ibuf_off;
            // interrupt source only while the pin is a plain input
            o_ext_int_src <= pin_input_value & cell_in_mode;
        end
    end

endmodule
`default_nettype wire

//--- tb/fpgp_port_checker.sv
// checker for the five-pin port: read timing, reserved bits and pad controls
// assumes it is bound to fpgp_port and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module fpgp_port_checker (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic [4:0] i_pin_in,
    input wire logic [4:0] o_pin_oe,
    input wire logic [4:0] o_pull_up_en,
    input wire logic [4:0] o_pull_down_en,
    input wire logic [4:0] o_schmitt_en,
    input wire logic [4:0] o_alt_in,
    input wire logic [4:0] o_ext_int_src
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    // edges since reset, so that deep history never reaches into reset
    logic [2:0] run;
    always_ff @(posedge i_clk) begin
        if (i_reset) run <= 3'h0;
        else if (run != 3'h4) run <= run + 3'h1;
    end
    function automatic logic [31:0] rmask(input logic [11:0] a);
        case (a)
            12'h000, 12'h004, 12'h008: rmask = 32'hFFFFFC00;
            12'h010: rmask = 32'hFFE0FFE0;
            12'h014, 12'h018: rmask = 32'hFFFFFFE0;
            12'h030: rmask = 32'hFFF00000;
            12'h100, 12'h104, 12'h108, 12'h10C, 12'h110: rmask = 32'hFFFFFFFE;
            default: rmask = 32'hFFFFFFFF;
        endcase
    endfunction
    sequence s_cfg_write;
        i_wr && i_addr == 12'h000;
    endsequence
    sequence s_cfg_read;
        i_rd && i_addr == 12'h000;
    endsequence
    a_rdata_idle: assert property (
        !$past(i_rd) |-> o_rdata == 32'h00000000) else $error("read data outside read slot");
    a_reserved_zero: assert property (
        $past(i_rd) |-> (o_rdata & rmask($past(i_addr))) == 32'h00000000) else $error("reserved bits set");
    a_cfg_readback: assert property (
        s_cfg_write ##1 s_cfg_read |=> o_rdata == ($past(i_wdata, 2) & 32'h000003FF))
        else $error("mode field readback wrong");
    a_pull_excl: assert property (
        (o_pull_up_en & o_pull_down_en) == 5'h00) else $error("both pulls on");
    a_reset_pads: assert property (
        $past(i_reset) |-> o_pin_oe == 5'h00 && o_pull_up_en == 5'h00 && o_pull_down_en == 5'h00
        && o_schmitt_en == 5'h1F && o_alt_in == 5'h00 && o_ext_int_src == 5'h00)
        else $error("pads not at reset state");
    a_alt_in_sync: assert property (
        run == 3'h4 && o_schmitt_en == 5'h1F && $past(o_schmitt_en) == 5'h1F |-> o_alt_in == $past(i_pin_in, 3))
        else $error("pin level not passed in three cycles");
    a_ibuf_gate: assert property (
        $past(o_schmitt_en) == o_schmitt_en |-> (o_alt_in & ~o_schmitt_en) == 5'h00)
        else $error("disabled input passes level");
    a_ext_int_gate: assert property (
        (o_ext_int_src & ~o_schmitt_en & ~$past(o_schmitt_en) & ~$past(o_schmitt_en, 2)) == 5'h00)
        else $error("interrupt source from disabled input");
endmodule
bind fpgp_port fpgp_port_checker u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(i_pin_in),
    .o_pin_oe(o_pin_oe), .o_pull_up_en(o_pull_up_en), .o_pull_down_en(o_pull_down_en),
    .o_schmitt_en(o_schmitt_en), .o_alt_in(o_alt_in), .o_ext_int_src(o_ext_int_src));
`default_nettype wire

//--- tb/fpgp_pad_model.sv
// pad model of the five pins: port drivers, weak pulls, an outside source
// assumes the port's registered pad controls and a bench-driven source
`timescale 1ns/100ps
`default_nettype none
module fpgp_pad_model (
    input wire logic i_clk,
    input wire logic [4:0] i_out,
    input wire logic [4:0] i_oe,
    input wire logic [4:0] i_pu,
    input wire logic [4:0] i_pd,
    input wire logic [4:0] i_ext_en,
    input wire logic [4:0] i_ext_val,
    output logic [4:0] o_level
);
    logic [4:0] last = 5'h00;
    // a pin nobody drives or pulls wanders, so it never keeps its old level
    always_comb o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val)
        | (~i_oe & ~i_ext_en & (i_pu | (~i_pd & ~last)));
    always @(posedge i_clk) last <= o_level;
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// testbench of the five-pin port: register tasks and one task a scenario
// assumes the pad model on the pins and the checker bound to the port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [11:0] i_addr = 12'h000;
    logic [31:0] i_wdata = 32'h00000000;
    logic [4:0] i_alt_out = 5'h00;
    logic [4:0] i_alt_oe = 5'h00;
    logic [4:0] ext_en = 5'h00;
    logic [4:0] ext_val = 5'h00;
    wire [31:0] o_rdata;
    wire [4:0] i_pin_in, o_pin_out, o_pin_oe, o_pull_up_en, o_pull_down_en, o_schmitt_en, o_alt_in, o_ext_int_src;
    int num_errors = 0;
    int compares = 0;
    always #12.5 i_clk = ~i_clk;
    fpgp_port uut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
        .o_pull_up_en(o_pull_up_en), .o_pull_down_en(o_pull_down_en), .o_schmitt_en(o_schmitt_en),
        .i_alt_out(i_alt_out), .i_alt_oe(i_alt_oe), .o_alt_in(o_alt_in), .o_ext_int_src(o_ext_int_src));
    fpgp_pad_model pads (.i_clk(i_clk), .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pu(o_pull_up_en),
        .i_pd(o_pull_down_en), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(i_pin_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // may follow a write at once, giving a back-to-back write and read
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp, what);
    endtask
    // five edges cover pad update plus the three-flop input path
    task automatic pad(input logic [19:0] exp);
        repeat (5) @(posedge i_clk);
        #1 chk({o_pin_oe, o_pull_up_en, o_pull_down_en, o_schmitt_en}, exp, "pads");
    endtask
    task automatic s_reset;
        logic [11:0] regs [7] = '{12'h000, 12'h004, 12'h008, 12'h014, 12'h018, 12'h030, 12'h100};
        foreach (regs[i]) rd(regs[i], 32'h0, "reset reg");
        pad({5'h00, 5'h00, 5'h00, 5'h1F});
        chk(o_pin_out, 5'h00, "out");
    endtask
    task automatic s_push;
        wr(12'h004, 32'h000002AA);
        wr(12'h000, 32'hFFFFFFFF);
        rd(12'h000, 32'h3FF, "mode");
        pad({5'h00, 5'h00, 5'h00, 5'h1F});
        wr(12'h000, 32'h155);
        wr(12'h014, 32'h0A);
        pad({5'h1F, 5'h00, 5'h00, 5'h1F});
        chk(o_pin_out, 5'h0A, "out");
        chk(o_ext_int_src, 5'h00, "int src");
        rd(12'h010, 32'h0A, "input");
        wr(12'h010, 32'h001F001F);
        pad({5'h1F, 5'h00, 5'h00, 5'h1F});
        rd(12'h010, 32'h001F0015, "input inv");
    endtask
    task automatic s_drain;
        wr(12'h000, 32'h2AA);
        pad({5'h0A, 5'h00, 5'h00, 5'h1F});
        chk(o_pin_out, 5'h00, "out");
    endtask
    task automatic s_input;
        ext_en <= 5'h1F;
        ext_val <= 5'h15;
        wr(12'h010, 32'h0);
        wr(12'h000, 32'h0);
        wr(12'h004, 32'h1E4);
        pad({5'h00, 5'h04, 5'h12, 5'h1F});
        rd(12'h010, 32'h15, "input");
        chk(o_ext_int_src, 5'h15, "int src");
        chk(o_alt_in, 5'h15, "alt in");
    endtask
    task automatic s_analog;
        wr(12'h004, 32'h0);
        wr(12'h008, 32'h2C0);
        pad({5'h00, 5'h00, 5'h00, 5'h07});
        rd(12'h010, 32'h05, "input");
        chk(o_alt_in, 5'h05, "alt in");
        chk(o_ext_int_src, 5'h05, "int src");
        wr(12'h008, 32'h0);
    endtask
    task automatic s_lock;
        wr(12'h014, 32'h0);
        wr(12'h018, 32'h2);
        wr(12'h014, 32'h1F);
        rd(12'h014, 32'h1D, "out reg");
        wr(12'h104, 32'h1);
        rd(12'h104, 32'h0, "bit ctl");
        wr(12'h108, 32'h0);
        rd(12'h014, 32'h19, "out reg");
        wr(12'h018, 32'h0);
        wr(12'h104, 32'h1);
        rd(12'h014, 32'h1B, "out reg");
        rd(12'h10C, 32'h1, "bit ctl");
    endtask
    task automatic s_alt;
        i_alt_oe <= 5'h01;
        wr(12'h030, 32'h1);
        wr(12'h000, 32'h1);
        wr(12'h004, 32'h2);
        pad({5'h01, 5'h01, 5'h00, 5'h1F});
        chk(o_pin_out[0], 1'b0, "alt out");
        // output bit cleared, peripheral high: the pin must follow the peripheral
        i_alt_out <= 5'h01;
        wr(12'h014, 32'h0);
        pad({5'h01, 5'h01, 5'h00, 5'h1F});
        chk(o_pin_out[0], 1'b1, "alt out");
        wr(12'h000, 32'h2);
        pad({5'h01, 5'h01, 5'h00, 5'h1F});
        chk(o_pin_out[0], 1'b0, "alt drain out");
        i_alt_oe <= 5'h00;
        pad({5'h00, 5'h01, 5'h00, 5'h1F});
        rd(12'h020, 32'h0, "unmapped");
        rd(12'h114, 32'h0, "unmapped");
        wr(12'h020, 32'hFFFFFFFF);
        rd(12'h030, 32'h1, "alt sel");
    endtask
    task automatic give_verdict;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        s_reset;
        s_push;
        s_drain;
        s_input;
        s_analog;
        s_lock;
        s_alt;
        give_verdict;
    end
    // the scenarios need about 130 cycles; two thousand means a hang
    initial begin
        #50000;
        num_errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
